/* File: core/elsc_consts.svh */
// register offsets, bit positions and reset values for the line and store control bank
`ifndef ELSC_CONSTS_SVH
`define ELSC_CONSTS_SVH
`define ELSC_ADDR_W            8
`define ELSC_DATA_W            8
`define ELSC_OFS_LINE_STORE    8'h1D
`define ELSC_OFS_MON_ALIGN     8'hAA
`define ELSC_RST_LINE_STORE    8'h00
`define ELSC_RST_MON_ALIGN     8'h00
`define ELSC_BIT_LINE_IF_RST   7
`define ELSC_BIT_RX_ALIGN      6
`define ELSC_BIT_TX_ALIGN      5
`define ELSC_CHSEL_MSB         4
`define ELSC_CHSEL_LSB         0
`define ELSC_BIT_OPEN_DRAIN    7
`define ELSC_BIT_DISCONNECT    6
`define ELSC_BIT_SYNC_MODE     5
`define ELSC_BIT_TXCLK_SRC     2
`define ELSC_BIT_RX_STORE_RST  1
`define ELSC_BIT_TX_STORE_RST  0
`define ELSC_LS_WMASK          8'hE7
`endif

/* File: core/elsc_ctrl.sv */
// line and store control registers with command edge detection
`timescale 1ns/1ps
`include "elsc_consts.svh"
// How it works
// - a written zero-to-one of the line interface reset bit pulses a reset of recovery and jitter logic.
// - a rise of the receive align bit forces half-frame pointer spacing only if spacing is below half.
// - a rise of the transmit align bit forces half-frame pointer spacing only if spacing is below half.
// - a five-bit field picks which receive channel is copied into the receive channel monitor register.
// - the receiver mode bit picks normal E1 or 2.048MHz sync input and leaves the transmitter alone.
// - with the clock source bit set the transmit side uses the recovered clock, else the loss-mux bit.
// - a rise of the receive store reset bit forces the receive elastic store to one frame depth.
// - a rise of the transmit store reset bit forces the transmit elastic store to one frame depth.
module elsc_ctrl #(
    parameter int CHAN_W = 5
) (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rst_b,
    input  wire logic                      i_ce,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    input  wire logic [`ELSC_ADDR_W-1:0]   i_addr,
    input  wire logic [`ELSC_DATA_W-1:0]   i_wdata,
    output logic      [`ELSC_DATA_W-1:0]   o_rdata,
    input  wire logic                      i_rx_system_clock,
    input  wire logic                      i_rx_sys_rst_b,
    input  wire logic                      i_tx_system_clock,
    input  wire logic                      i_tx_sys_rst_b,
    input  wire logic                      i_rx_sep_below_half,
    input  wire logic                      i_tx_sep_below_half,
    input  wire logic [7:0]                i_rx_chan_data,
    input  wire logic                      i_rx_chan_strobe,
    input  wire logic [CHAN_W-1:0]         i_rx_chan_num,
    input  wire logic                      i_line_data_pos,
    input  wire logic                      i_line_data_neg,
    input  wire logic                      i_tx_clock_loss_mux_ctrl,
    input  wire logic                      i_tx_clock_lost,
    output logic                           o_line_if_reset,
    output logic                           o_rx_store_align,
    output logic                           o_tx_store_align,
    output logic                           o_rx_store_reset,
    output logic                           o_tx_store_reset,
    output logic [7:0]                     o_rx_channel_monitor_reg,
    output logic                           o_line_out_pos,
    output logic                           o_line_out_neg,
    output logic                           o_line_open_drain,
    output elsc_pkg::elsc_rx_mode_t        o_rx_sync_signal_mode,
    output logic                           o_tx_use_recovered_clk
);
    logic [7:0] mon_align_reg;
    logic [7:0] line_store_reg;
    logic [7:0] chan_mon_reg;
    logic       phase_reg;
    logic       pos_reg;
    logic       neg_reg;
    logic       lost_s1_reg;
    logic       lost_s2_reg;
    logic       lif_pulse_reg;
    logic       rx_align_raw;
    logic       tx_align_raw;
    logic       wr_ma;
    logic       wr_ls;

    assign wr_ma = i_wr && (i_addr == `ELSC_OFS_MON_ALIGN);
    assign wr_ls = i_wr && (i_addr == `ELSC_OFS_LINE_STORE);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            mon_align_reg <= `ELSC_RST_MON_ALIGN;
        end else if (i_ce && wr_ma) begin
            mon_align_reg <= i_wdata;
        end
    end

    // unassigned bits held at zero so reads show what is really kept
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            line_store_reg <= `ELSC_RST_LINE_STORE;
        end else if (i_ce && wr_ls) begin
            line_store_reg <= i_wdata & `ELSC_LS_WMASK;
        end
    end

    always_comb begin
        o_rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `ELSC_OFS_MON_ALIGN: begin
                    o_rdata = mon_align_reg;
                end
                `ELSC_OFS_LINE_STORE: begin
                    o_rdata = line_store_reg;
                end
                default: begin
                    o_rdata = 8'h00;
                end
            endcase
        end
    end

    // line reset pulse, local clock domain
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            lif_pulse_reg <= 1'b0;
        end else if (i_ce) begin
            lif_pulse_reg <= wr_ma && !mon_align_reg[`ELSC_BIT_LINE_IF_RST]
                             && i_wdata[`ELSC_BIT_LINE_IF_RST];
        end
    end
    assign o_line_if_reset = lif_pulse_reg;

    // toggle handoff needs rises spaced by a few store clocks
    // edge detect per command, crossing to its own domain
    elsc_rise_pulse u_rx_align (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_ce        (i_ce),
        .i_wr        (wr_ma),
        .i_old       (mon_align_reg[`ELSC_BIT_RX_ALIGN]),
        .i_new       (i_wdata[`ELSC_BIT_RX_ALIGN]),
        .i_dst_clk   (i_rx_system_clock),
        .i_dst_rst_b (i_rx_sys_rst_b),
        .o_pulse     (rx_align_raw)
    );
    elsc_rise_pulse u_tx_align (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_ce        (i_ce),
        .i_wr        (wr_ma),
        .i_old       (mon_align_reg[`ELSC_BIT_TX_ALIGN]),
        .i_new       (i_wdata[`ELSC_BIT_TX_ALIGN]),
        .i_dst_clk   (i_tx_system_clock),
        .i_dst_rst_b (i_tx_sys_rst_b),
        .o_pulse     (tx_align_raw)
    );
    elsc_rise_pulse u_rx_reset (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_ce        (i_ce),
        .i_wr        (wr_ls),
        .i_old       (line_store_reg[`ELSC_BIT_RX_STORE_RST]),
        .i_new       (i_wdata[`ELSC_BIT_RX_STORE_RST]),
        .i_dst_clk   (i_rx_system_clock),
        .i_dst_rst_b (i_rx_sys_rst_b),
        .o_pulse     (o_rx_store_reset)
    );
    elsc_rise_pulse u_tx_reset (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_ce        (i_ce),
        .i_wr        (wr_ls),
        .i_old       (line_store_reg[`ELSC_BIT_TX_STORE_RST]),
        .i_new       (i_wdata[`ELSC_BIT_TX_STORE_RST]),
        .i_dst_clk   (i_tx_system_clock),
        .i_dst_rst_b (i_tx_sys_rst_b),
        .o_pulse     (o_tx_store_reset)
    );

    // a rise while spacing is fine is dropped, not held for later
    // align only when spacing is short; status is in the store's own domain
    assign o_rx_store_align = rx_align_raw && i_rx_sep_below_half;
    assign o_tx_store_align = tx_align_raw && i_tx_sep_below_half;

    // only the newest byte of the chosen channel is kept
    // capture selected receive channel
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            chan_mon_reg <= 8'h00;
        end else if (i_ce && i_rx_chan_strobe
                     && i_rx_chan_num == mon_align_reg[`ELSC_CHSEL_MSB:`ELSC_CHSEL_LSB]) begin
            chan_mon_reg <= i_rx_chan_data;
        end
    end
    assign o_rx_channel_monitor_reg = chan_mon_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            phase_reg <= 1'b0;
        end else if (i_ce) begin
            phase_reg <= line_store_reg[`ELSC_BIT_DISCONNECT] && !phase_reg;
        end
    end

    // pattern rides on the positive rail only, negative rail held idle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
        end else if (i_ce) begin
            if (line_store_reg[`ELSC_BIT_DISCONNECT]) begin
                pos_reg <= ~phase_reg;
                neg_reg <= 1'b0;
            end else begin
                pos_reg <= i_line_data_pos;
                neg_reg <= i_line_data_neg;
            end
        end
    end
    assign o_line_out_pos    = pos_reg;
    assign o_line_out_neg    = neg_reg;
    assign o_line_open_drain = line_store_reg[`ELSC_BIT_OPEN_DRAIN];

    // loss flag comes from the transmit clock monitor, two stages before use
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            lost_s1_reg <= 1'b0;
            lost_s2_reg <= 1'b0;
        end else if (i_ce) begin
            lost_s1_reg <= i_tx_clock_lost;
            lost_s2_reg <= lost_s1_reg;
        end
    end

    assign o_rx_sync_signal_mode = line_store_reg[`ELSC_BIT_SYNC_MODE]
                                   ? elsc_pkg::ELSC_RX_SYNC : elsc_pkg::ELSC_RX_E1;
    // forced recovered clock, else loss-mux control decides
    assign o_tx_use_recovered_clk = line_store_reg[`ELSC_BIT_TXCLK_SRC]
                                    || (i_tx_clock_loss_mux_ctrl && lost_s2_reg);
endmodule

/* File: core/elsc_pkg.sv */
// types shared by the line and store control bank
package elsc_pkg;
    typedef enum logic {
        ELSC_RX_E1,
        ELSC_RX_SYNC
    } elsc_rx_mode_t;
endpackage

/* File: core/elsc_rise_pulse.sv */
// rising-edge detect of a written command bit, pulse handed across by toggle sync
`timescale 1ns/1ps
module elsc_rise_pulse (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    input  wire logic i_wr,
    input  wire logic i_old,
    input  wire logic i_new,
    input  wire logic i_dst_clk,
    input  wire logic i_dst_rst_b,
    output logic      o_pulse
);
    logic tgl_reg;
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            tgl_reg <= 1'b0;
        end else if (i_ce && i_wr && !i_old && i_new) begin
            tgl_reg <= ~tgl_reg;
        end
    end

    // destination runs free; first stage only feeds second
    always_ff @(posedge i_dst_clk) begin
        if (!i_dst_rst_b) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= tgl_reg;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign o_pulse = s2_reg ^ s3_reg;
endmodule

/* File: dv/elsc_ctrl_chk.sv */
// port assertions for the line and store control bank
`timescale 1ns/1ps
module elsc_ctrl_chk #(parameter int CHAN_W = 5) (
    input wire logic i_clk_sys, i_rst_b, i_ce, i_wr, i_rx_chan_strobe,
    input wire logic [7:0] i_addr, i_wdata, i_rx_chan_data, o_rx_channel_monitor_reg,
    input wire logic [CHAN_W-1:0] i_rx_chan_num,
    input wire logic i_line_data_pos, i_line_data_neg, i_tx_clock_loss_mux_ctrl,
    input wire logic i_tx_clock_lost, o_line_if_reset, o_line_out_pos, o_line_out_neg,
    input wire elsc_pkg::elsc_rx_mode_t o_rx_sync_signal_mode,
    input wire logic o_tx_use_recovered_clk
);
    logic [7:0] saa, s1d;
    logic [1:0] lq;
    wire logic wa = i_ce && i_wr && i_addr == 8'hAA;
    wire logic w1 = i_ce && i_wr && i_addr == 8'h1D;
    wire logic lossy = i_tx_clock_loss_mux_ctrl & lq[1];
    wire logic hit = i_ce && i_rx_chan_strobe && i_rx_chan_num == saa[CHAN_W-1:0];
    // shadow copies so outputs can be tied to what was written
    always_ff @(posedge i_clk_sys) saa <= !i_rst_b ? 8'h00 : wa ? i_wdata : saa;
    always_ff @(posedge i_clk_sys) s1d <= !i_rst_b ? 8'h00 : w1 ? (i_wdata & 8'hE7) : s1d;
    always_ff @(posedge i_clk_sys) lq <= !i_rst_b ? 2'b00 : i_ce ? {lq[0], i_tx_clock_lost} : lq;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    a_lir_rise: assert property (wa && i_wdata[7] && !saa[7] |=> o_line_if_reset)
        else $error("line reset pulse missing");
    a_lir_only: assert property (i_ce && !(wa && i_wdata[7] && !saa[7]) |=> !o_line_if_reset)
        else $error("line reset pulse without a rise");
    a_mon_copy: assert property (hit |=> o_rx_channel_monitor_reg == $past(i_rx_chan_data))
        else $error("selected channel not copied");
    a_mon_hold: assert property (!hit |=> $stable(o_rx_channel_monitor_reg))
        else $error("channel monitor changed without a match");
    a_disc_alt: assert property ((s1d[6] && i_ce) [*3] |->
        o_line_out_pos != $past(o_line_out_pos) && !o_line_out_neg)
        else $error("disconnect pattern not alternating");
    a_data_pass: assert property ($past(i_rst_b) && $past(i_ce) && !$past(s1d[6]) |->
        o_line_out_pos == $past(i_line_data_pos) && o_line_out_neg == $past(i_line_data_neg))
        else $error("line data not passed through");
    a_mode_bit: assert property (o_rx_sync_signal_mode == elsc_pkg::elsc_rx_mode_t'(s1d[5]))
        else $error("receiver mode differs from register");
    a_clk_src: assert property (o_tx_use_recovered_clk == (s1d[2] | lossy))
        else $error("transmit clock source wrong");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_line_out_pos) && $stable(o_line_if_reset)
        && $stable(o_rx_channel_monitor_reg) && $stable(o_rx_sync_signal_mode))
        else $error("state moved while clock enable low");
    cover property (o_line_if_reset);
    cover property (!i_ce && i_wr);
    cover property (s1d[6] [*4]);
    cover property (hit);
endmodule
bind elsc_ctrl elsc_ctrl_chk #(.CHAN_W(CHAN_W)) i_chk (.*);

/* File: dv/elsc_host.sv */
// host model on the parallel control port
`timescale 1ns/1ps
module elsc_host (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr = 1'b0,
    output logic            o_rd = 1'b0,
    output logic [7:0]      o_addr = 8'h00,
    output logic [7:0]      o_wdata = 8'h00
);
    // trailing idle edge so back-to-back calls never drive a strobe twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        {o_wr, o_addr, o_wdata} <= {1'b1, a, v};
        @(posedge i_clk_sys);
        {o_wr, o_wdata} <= {1'b0, ~v};
        @(posedge i_clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        {o_rd, o_addr} <= {1'b1, a};
        @(posedge i_clk_sys);
        v = i_rdata;
        o_rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask
endmodule

/* File: dv/test_elsc_ctrl.sv */
// self-checking bench for the line and store control bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_elsc_ctrl;
    logic clk = 0, rxc = 0, txc = 0, rst_b = 0, wr, rd, strb = 0, dp = 0, dn = 0;
    logic mux = 0, lost = 0, rsep = 0, tsep = 0, lir, rxa, txa, rxr, txr, pos, neg, rec, od;
    logic ce = 1'b1;
    logic [7:0] addr, wdata, rdata, cdat = 8'h00, mon, d;
    logic [4:0] cnum = 5'h00;
    elsc_pkg::elsc_rx_mode_t mode;
    int failures = 0, num_checks = 0;
    logic [7:0] n_lir = 8'h00, n_rxa = 8'h00, n_txa = 8'h00, n_rxr = 8'h00, n_txr = 8'h00;
    always #2.5 clk = ~clk;
    always #3.5 rxc = ~rxc;
    always #4.5 txc = ~txc;
    always @(posedge clk) {dp, dn} <= {dn, ~dp};
    // counted as 4-state so an unknown pulse shows up in the totals
    always @(posedge clk) if (rst_b) n_lir <= n_lir + lir;
    always @(posedge rxc) if (rst_b) n_rxa <= n_rxa + rxa;
    always @(posedge rxc) if (rst_b) n_rxr <= n_rxr + rxr;
    always @(posedge txc) if (rst_b) n_txa <= n_txa + txa;
    always @(posedge txc) if (rst_b) n_txr <= n_txr + txr;
    elsc_host i_host (.i_clk_sys(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata));
    elsc_ctrl i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce), .i_wr(wr), .i_rd(rd),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_rx_system_clock(rxc),
        .i_rx_sys_rst_b(rst_b), .i_tx_system_clock(txc), .i_tx_sys_rst_b(rst_b),
        .i_rx_sep_below_half(rsep), .i_tx_sep_below_half(tsep), .i_rx_chan_data(cdat),
        .i_rx_chan_strobe(strb), .i_rx_chan_num(cnum), .i_line_data_pos(dp),
        .i_line_data_neg(dn), .i_tx_clock_loss_mux_ctrl(mux), .i_tx_clock_lost(lost),
        .o_line_if_reset(lir), .o_rx_store_align(rxa), .o_tx_store_align(txa),
        .o_rx_store_reset(rxr), .o_tx_store_reset(txr), .o_rx_channel_monitor_reg(mon),
        .o_line_out_pos(pos), .o_line_out_neg(neg), .o_line_open_drain(od),
        .o_rx_sync_signal_mode(mode), .o_tx_use_recovered_clk(rec));
    // store pulses land two to three store clocks late
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic t_regs;
        i_host.rd(8'h1D, d);
        `CHK(d, 8'h00)
        i_host.wr(8'h55, 8'h80);
        i_host.rd(8'h55, d);
        `CHK(d, 8'h00)
        `CHK(n_lir, 0)
    endtask
    task automatic t_line_reset;
        i_host.wr(8'hAA, 8'h80);
        i_host.wr(8'hAA, 8'h80);
        wt(2);
        `CHK(n_lir, 1)
        i_host.wr(8'hAA, 8'h00);
        i_host.wr(8'hAA, 8'h80);
        wt(2);
        `CHK(n_lir, 2)
    endtask
    task automatic t_align;
        rsep <= 1'b1;
        i_host.wr(8'hAA, 8'h60);
        wt(12);
        `CHK(n_rxa, 1)
        `CHK(n_txa, 0)
        {rsep, tsep} <= 2'b01;
        i_host.wr(8'hAA, 8'h00);
        wt(12);
        i_host.wr(8'hAA, 8'h60);
        wt(12);
        `CHK(n_rxa, 1)
        `CHK(n_txa, 1)
    endtask
    task automatic t_store;
        i_host.wr(8'h1D, 8'h02);
        wt(12);
        i_host.wr(8'h1D, 8'h1B);
        wt(12);
        i_host.rd(8'h1D, d);
        `CHK(d, 8'h03)
        `CHK(n_rxr, 1)
        `CHK(n_txr, 1)
    endtask
    task automatic t_mode;
        i_host.wr(8'h1D, 8'h20);
        `CHK(mode, elsc_pkg::ELSC_RX_SYNC)
        `CHK(rec, 1'b0)
        {mux, lost} <= 2'b11;
        // loss flag passes a two-stage synchroniser
        wt(3);
        `CHK(rec, 1'b1)
        mux <= 1'b0;
        i_host.wr(8'h1D, 8'h04);
        `CHK(rec, 1'b1)
        `CHK(mode, elsc_pkg::ELSC_RX_E1)
    endtask
    task automatic t_disc;
        i_host.wr(8'h1D, 8'h40);
        for (int k = 0; k < 4; k++) begin
            wt(1);
            d = {d[6:0], pos};
            `CHK(neg, 1'b0)
        end
        `CHK(d[3:0], 4'hA)
        i_host.wr(8'h1D, 8'h00);
    endtask
    task automatic t_mon;
        i_host.wr(8'hAA, 8'h1F);
        {strb, cnum, cdat} <= {1'b1, 5'h1F, 8'hA5};
        wt(1);
        {cnum, cdat} <= {5'h1E, 8'h5A};
        wt(1);
        strb <= 1'b0;
        wt(1);
        `CHK(mon, 8'hA5)
    endtask
    task automatic t_freeze;
        ce <= 1'b0;
        i_host.wr(8'h1D, 8'h80);
        i_host.wr(8'hAA, 8'hE0);
        i_host.rd(8'h1D, d);
        `CHK(d, 8'h00)
        `CHK(od, 1'b0)
        wt(12);
        `CHK(n_lir, 2)
        `CHK(n_txa, 1)
        ce <= 1'b1;
        i_host.wr(8'h1D, 8'h80);
        `CHK(od, 1'b1)
        i_host.rd(8'hAA, d);
        `CHK(d, 8'h1F)
        i_host.wr(8'h1D, 8'h00);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        wt(16);
        rst_b <= 1'b1;
        wt(1);
        t_regs();
        t_line_reset();
        t_align();
        t_store();
        t_mode();
        t_disc();
        t_mon();
        t_freeze();
        finish_test();
    end
endmodule
